// *** design/apo_pkg.sv ***
// Types of the audio PWM output stage
package apo_pkg;

  typedef enum logic [1:0] {
    APO_RES8 = 2'b00,
    APO_RES10 = 2'b01,
    APO_RES12 = 2'b10
  } apo_res_e;

  typedef logic [3:0] apo_nib_t;

endpackage : apo_pkg

// *** design/apo_pwm_out.sv ***
// Audio PWM output stage with sample registers and saturator port
// Operation
// - PWM resolution selectable as 8, 10 or 12 bits.
// - Sample top bit is the sign, zero positive, one negative.
// - Sample built from nibbles at 08H, 0AH, 0BH, write only.
// - Saturator clamps 16-bit input to 12 bits feeding interpolation.
// - Delta-sigma interpolation lets output play at up to 256 kHz.
// - Port 13H takes four nibble writes, returns three nibble reads.
// - Each PWM interrupt request sets status bit D2 at 00H.
// - Control 09H: D0 enables output, D1 enables audio interrupt.
// - At each code end pending sample goes active, interrupt raised.
// - Without a new sample the previous one is reused.
// - With output disabled both speaker outputs are driven low.
// - Halt clears output enable and floats both speaker outputs.
// - Bit D1 at 11H selects offset format instead of signed.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "apo_regs.svh"
module apo_pwm_out import apo_pkg::*; #(
  parameter int TICK_DIV = `APO_TICK_DIV
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`APO_ADDR_W-1:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [3:0] reg_rdata,
  input wire logic halt_req,
  output logic speaker_out_pos,
  output logic speaker_out_neg,
  output logic speaker_oe,
  output logic audio_irq,
  output logic wake_enable
);

  initial begin
    if (TICK_DIV < 1 || TICK_DIV > 255) begin
      $error("apo_pwm_out: TICK_DIV out of range");
    end
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic output_enable_bit_ff;
  logic audio_irq_enable_bit_ff;
  logic audio_irq_flag_ff;
  logic sample_format_bit_ff;
  logic wake_ff;
  logic halted_ff;
  apo_res_e res_ff;
  logic [11:0] sample_word_ff;
  logic [11:0] active_ff;
  logic [15:0] sat_in_ff;
  logic [1:0] sat_wcnt_ff;
  logic [1:0] sat_rcnt_ff;
  logic [11:0] sat_res;
  logic [7:0] div_ff;
  logic [11:0] cnt_ff;
  logic [11:0] code_ff;
  logic [3:0] err_ff;
  logic tick;
  logic frame_end;
  logic en_rise;
  logic wr_ctrl;
  logic wr_sat_last;
  logic [11:0] max_cnt;
  logic [11:0] nxt_code;
  logic [3:0] nxt_err;

  assign wr_ctrl = reg_wr && reg_addr == `APO_OFF_CTRL;
  assign wr_sat_last = reg_wr && reg_addr == `APO_OFF_SAT &&
    sat_wcnt_ff == 2'd3;
  assign en_rise = wr_ctrl && reg_wdata[`APO_CTRL_EN_BIT] &&
    !output_enable_bit_ff && !halt_req;

  // ------------------------------------------------------------
  // Control register and halt
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_enable_bit_ff <= 1'b0;
      audio_irq_enable_bit_ff <= 1'b0;
    end else if (halt_req) begin
      output_enable_bit_ff <= 1'b0;
    end else if (wr_ctrl) begin
      output_enable_bit_ff <= reg_wdata[`APO_CTRL_EN_BIT];
      audio_irq_enable_bit_ff <= reg_wdata[`APO_CTRL_IRQEN_BIT];
    end
  end

  // Pins float from halt until software enables output again
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      halted_ff <= 1'b0;
    end else if (halt_req) begin
      halted_ff <= 1'b1;
    end else if (wr_ctrl && reg_wdata[`APO_CTRL_EN_BIT]) begin
      halted_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_format_bit_ff <= 1'b0;
      wake_ff <= 1'b0;
      res_ff <= APO_RES12;
    end else if (reg_wr && reg_addr == `APO_OFF_FMT) begin
      sample_format_bit_ff <= reg_wdata[`APO_FMT_FMT_BIT];
      wake_ff <= reg_wdata[`APO_FMT_WAKE_BIT];
    end else if (reg_wr && reg_addr == `APO_OFF_RES) begin
      if (reg_wdata[1:0] == 2'b11) begin
        res_ff <= APO_RES12;
      end else begin
        res_ff <= apo_res_e'(reg_wdata[1:0]);
      end
    end
  end

  // ------------------------------------------------------------
  // Status flag: hardware set wins over software clear
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      audio_irq_flag_ff <= 1'b0;
    end else if (frame_end) begin
      audio_irq_flag_ff <= 1'b1;
    end else if (reg_wr && reg_addr == `APO_OFF_STATUS &&
        !reg_wdata[`APO_STAT_IRQ_BIT]) begin
      audio_irq_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      audio_irq <= 1'b0;
    end else begin
      audio_irq <= audio_irq_flag_ff && audio_irq_enable_bit_ff;
    end
  end

  // ------------------------------------------------------------
  // Pending sample nibbles
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_word_ff <= `APO_RST_SAMPLE;
    end else if (wr_sat_last) begin
      sample_word_ff <= sat_res;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `APO_OFF_SMP_LO: sample_word_ff[3:0] <= reg_wdata;
        `APO_OFF_SMP_MID: sample_word_ff[7:4] <= reg_wdata;
        `APO_OFF_SMP_HI: sample_word_ff[11:8] <= reg_wdata;
        default: sample_word_ff <= sample_word_ff;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Saturator port: low nibble first in both directions
  // ------------------------------------------------------------
  apo_saturator #(
    .IN_W(16),
    .OUT_W(12)
  ) u_sat (
    .mix_in({reg_wdata, sat_in_ff[15:4]}),
    .clamp_out(sat_res)
  );

  logic [11:0] sat_hold_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sat_in_ff <= `APO_RST_SAT_IN;
      sat_wcnt_ff <= 2'd0;
      sat_hold_ff <= `APO_RST_SAMPLE;
    end else if (reg_wr && reg_addr == `APO_OFF_SAT) begin
      sat_in_ff <= {reg_wdata, sat_in_ff[15:4]};
      sat_wcnt_ff <= sat_wcnt_ff + 2'd1;
      if (wr_sat_last) begin
        sat_hold_ff <= sat_res;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sat_rcnt_ff <= 2'd0;
    end else if (wr_sat_last) begin
      sat_rcnt_ff <= 2'd0;
    end else if (reg_rd && reg_addr == `APO_OFF_SAT) begin
      sat_rcnt_ff <= (sat_rcnt_ff == 2'd2) ? 2'd0 : sat_rcnt_ff + 2'd1;
    end
  end

  // ------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `APO_RST_NIB;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `APO_OFF_STATUS: reg_rdata <= {1'b0, audio_irq_flag_ff, 2'b00};
        `APO_OFF_CTRL:
          reg_rdata <= {2'b00, audio_irq_enable_bit_ff,
            output_enable_bit_ff};
        `APO_OFF_FMT: reg_rdata <= {wake_ff, 1'b0, sample_format_bit_ff,
          1'b0};
        `APO_OFF_SAT: reg_rdata <= sat_hold_ff[sat_rcnt_ff*4 +: 4];
        `APO_OFF_RES: reg_rdata <= {2'b00, res_ff};
        default: reg_rdata <= `APO_RST_NIB;
      endcase
    end else begin
      reg_rdata <= `APO_RST_NIB;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_enable <= 1'b0;
    end else begin
      wake_enable <= wake_ff;
    end
  end

  // ------------------------------------------------------------
  // Step divider and frame counter
  // ------------------------------------------------------------
  assign tick = div_ff == 8'(TICK_DIV - 1);
  always_comb begin
    unique case (res_ff)
      APO_RES8: max_cnt = 12'h0FF;
      APO_RES10: max_cnt = 12'h3FF;
      APO_RES12: max_cnt = 12'hFFF;
    endcase
  end
  assign frame_end = output_enable_bit_ff && tick && cnt_ff == max_cnt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_ff <= 8'h00;
      cnt_ff <= 12'h000;
    end else if (!output_enable_bit_ff) begin
      div_ff <= 8'h00;
      cnt_ff <= 12'h000;
    end else if (tick) begin
      div_ff <= 8'h00;
      cnt_ff <= frame_end ? 12'h000 : cnt_ff + 12'h001;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Format, delta-sigma requantise, sample transfer
  // ------------------------------------------------------------
  logic [11:0] duty;
  logic [12:0] sum;
  logic [3:0] low_mask;
  assign duty = sample_format_bit_ff ? sample_word_ff
    : sample_word_ff ^ 12'h800;
  assign sum = {1'b0, duty} + {9'h000, (en_rise ? 4'h0 : err_ff)};

  always_comb begin
    unique case (res_ff)
      APO_RES8: low_mask = 4'hF;
      APO_RES10: low_mask = 4'h3;
      APO_RES12: low_mask = 4'h0;
    endcase
    if (sum[12]) begin
      nxt_code = max_cnt;
      nxt_err = 4'h0;
    end else begin
      nxt_err = sum[3:0] & low_mask;
      unique case (res_ff)
        APO_RES8: nxt_code = {4'h0, sum[11:4]};
        APO_RES10: nxt_code = {2'h0, sum[11:2]};
        APO_RES12: nxt_code = sum[11:0];
      endcase
    end
  end

  // Enable loads the sample written beforehand
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_ff <= `APO_RST_SAMPLE;
      code_ff <= 12'h000;
      err_ff <= 4'h0;
    end else if (frame_end || en_rise) begin
      active_ff <= sample_word_ff;
      code_ff <= nxt_code;
      err_ff <= nxt_err;
    end
  end

  // ------------------------------------------------------------
  // Differential speaker pins
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      speaker_out_pos <= 1'b0;
      speaker_out_neg <= 1'b0;
      speaker_oe <= 1'b1;
    end else begin
      speaker_out_pos <= output_enable_bit_ff && cnt_ff < code_ff;
      speaker_out_neg <= output_enable_bit_ff &&
        cnt_ff < (max_cnt ^ code_ff);
      speaker_oe <= !(halted_ff || halt_req);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_code_end;
    frame_end;
  endsequence

  sequence s_sat_load;
    wr_sat_last ##1 (sat_hold_ff == $past(sat_res));
  endsequence

  property p_flag_set;
    @(posedge clk) disable iff (!arst_n)
    s_code_end |=> audio_irq_flag_ff ##1
      audio_irq == $past(audio_irq_enable_bit_ff);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("irq flag not raised at code end");

  property p_transfer;
    @(posedge clk) disable iff (!arst_n)
    s_code_end |=> active_ff == $past(sample_word_ff);
  endproperty
  a_transfer: assert property (p_transfer)
    else $error("pending sample not transferred");

  property p_reuse;
    @(posedge clk) disable iff (!arst_n)
    !frame_end && !en_rise |=> $stable(active_ff) && $stable(code_ff);
  endproperty
  a_reuse: assert property (p_reuse)
    else $error("active sample changed outside code end");

  property p_off_low;
    @(posedge clk) disable iff (!arst_n)
    !output_enable_bit_ff |=> !speaker_out_pos && !speaker_out_neg;
  endproperty
  a_off_low: assert property (p_off_low)
    else $error("speaker pins not low while disabled");

  property p_halt;
    @(posedge clk) disable iff (!arst_n)
    halt_req |=> !output_enable_bit_ff && !speaker_oe;
  endproperty
  a_halt: assert property (p_halt)
    else $error("halt did not disable and float output");

  property p_ctrl;
    @(posedge clk) disable iff (!arst_n)
    wr_ctrl && !halt_req |=>
      output_enable_bit_ff == $past(reg_wdata[0]) &&
      audio_irq_enable_bit_ff == $past(reg_wdata[1]);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control write not taken");

  property p_nib_hi;
    @(posedge clk) disable iff (!arst_n)
    reg_wr && reg_addr == `APO_OFF_SMP_HI |=>
      sample_word_ff[11:8] == $past(reg_wdata);
  endproperty
  a_nib_hi: assert property (p_nib_hi)
    else $error("high sample nibble not stored");

  property p_sat;
    @(posedge clk) disable iff (!arst_n)
    s_sat_load |-> (!sat_hold_ff[11] || sat_hold_ff[10:0] != 11'h000 ||
      $signed($past(u_sat.mix_in)) <= -16'sd2048);
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturator result out of range");

  property p_sat_order;
    @(posedge clk) disable iff (!arst_n)
    reg_rd && reg_addr == `APO_OFF_SAT && sat_rcnt_ff == 2'd2 &&
      !wr_sat_last |=> sat_rcnt_ff == 2'd0;
  endproperty
  a_sat_order: assert property (p_sat_order)
    else $error("saturator read counter did not wrap");

  property p_code_range;
    @(posedge clk) disable iff (!arst_n)
    s_code_end |=> code_ff <= max_cnt;
  endproperty
  a_code_range: assert property (p_code_range)
    else $error("PWM code above resolution");

  property p_format;
    @(posedge clk) disable iff (!arst_n)
    !sample_format_bit_ff |-> duty[11] == !sample_word_ff[11];
  endproperty
  a_format: assert property (p_format)
    else $error("sign bit not mapped");

  property p_rate;
    @(posedge clk) disable iff (!arst_n)
    tick && output_enable_bit_ff |=> !tick [*1] or (TICK_DIV == 1);
  endproperty
  a_rate: assert property (p_rate)
    else $error("step tick too fast");

endmodule : apo_pwm_out

// *** design/apo_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef APO_REGS_SVH
`define APO_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define APO_ADDR_W 5
`define APO_OFF_STATUS 5'h00
`define APO_OFF_SMP_LO 5'h08
`define APO_OFF_CTRL 5'h09
`define APO_OFF_SMP_MID 5'h0A
`define APO_OFF_SMP_HI 5'h0B
`define APO_OFF_FMT 5'h11
`define APO_OFF_SAT 5'h13
`define APO_OFF_RES 5'h1C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define APO_STAT_IRQ_BIT 2
`define APO_CTRL_EN_BIT 0
`define APO_CTRL_IRQEN_BIT 1
`define APO_FMT_FMT_BIT 1
`define APO_FMT_WAKE_BIT 3

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define APO_RST_NIB 4'h0
`define APO_RST_SAMPLE 12'h000
`define APO_RST_SAT_IN 16'h0000

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define APO_CLK_KHZ 100000
`define APO_MAX_RATE_KHZ 256
`define APO_STEPS_8BIT 256
// Least cycles per PWM step for the 256 kHz 8-bit frame, rounded up
`define APO_TICK_DIV \
  ((`APO_CLK_KHZ + `APO_MAX_RATE_KHZ * `APO_STEPS_8BIT - 1) / \
  (`APO_MAX_RATE_KHZ * `APO_STEPS_8BIT))

`endif

// *** design/apo_saturator.sv ***
// Signed clamp from a wide mixed value to the sample width
`timescale 1ns/1ps
module apo_saturator #(
  parameter int IN_W = 16,
  parameter int OUT_W = 12
) (
  input wire logic [IN_W-1:0] mix_in,
  output logic [OUT_W-1:0] clamp_out
);
  import apo_pkg::*;

  localparam logic signed [IN_W-1:0] MAX_V =
    IN_W'((1 << (OUT_W - 1)) - 1);
  localparam logic signed [IN_W-1:0] MIN_V = -MAX_V - IN_W'(1);

  initial begin
    if (OUT_W < 2 || IN_W <= OUT_W || IN_W > 31) begin
      $error("apo_saturator: unsupported widths");
    end
  end

  always_comb begin
    if ($signed(mix_in) > MAX_V) begin
      clamp_out = MAX_V[OUT_W-1:0];
    end else if ($signed(mix_in) < MIN_V) begin
      clamp_out = MIN_V[OUT_W-1:0];
    end else begin
      clamp_out = mix_in[OUT_W-1:0];
    end
  end

endmodule : apo_saturator

// *** verification/apo_pwm_out_tb_top.sv ***
// Self-checking bench of the audio PWM output stage
`timescale 1ns/1ps
`include "apo_regs.svh"
module apo_pwm_out_tb_top import apo_pkg::*; ;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int TD = 1;
  localparam int WMAX = 4200;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [`APO_ADDR_W-1:0] reg_addr = '0;
  apo_nib_t reg_wdata = 4'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic halt_req = 1'b0;
  logic clr = 1'b0;
  apo_nib_t reg_rdata;
  apo_nib_t rv;
  logic spk_pos, spk_neg, spk_oe, audio_irq, wake_enable, floated;
  logic [12:0] pos_hi, neg_hi;
  logic [15:0] v;
  logic [11:0] s, m;
  logic f;
  int bad_count = 0;
  int compares = 0;
  logic [15:0] corners [5] = '{16'h7FFF, 16'h8000, 16'h07FF, 16'hF800,
    16'h0800};

  always #5 clk = ~clk;

  apo_pwm_out #(.TICK_DIV(TD)) u_apo_pwm_out (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_req(halt_req),
    .speaker_out_pos(spk_pos), .speaker_out_neg(spk_neg),
    .speaker_oe(spk_oe), .audio_irq(audio_irq), .wake_enable(wake_enable));

  apo_speaker_model u_apo_speaker_model (.clk(clk), .arst_n(arst_n),
    .pos(spk_pos), .neg(spk_neg), .oe(spk_oe), .clr(clr),
    .pos_hi(pos_hi), .neg_hi(neg_hi), .floated(floated));

  // ------------------------------------------------------------
  // Checks and bus tasks
  // ------------------------------------------------------------
  task automatic fail(input string msg);
    bad_count++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail

  task automatic chk_reg(input apo_nib_t g, input apo_nib_t e);
    compares++;
    if (g !== e) fail($sformatf("nibble %h expected %h", g, e));
  endtask : chk_reg

  task automatic chk_pin(input logic g, input logic e);
    compares++;
    if (g !== e) fail($sformatf("pin %b expected %b", g, e));
  endtask : chk_pin

  task automatic chk_cnt(input logic [12:0] g, input logic [12:0] e);
    compares++;
    if (g !== e) fail($sformatf("high count %0d expected %0d", g, e));
  endtask : chk_cnt

  function automatic logic [11:0] sat(input logic [15:0] x);
    if ($signed(x) > 16'sd2047) return 12'h7FF;
    if ($signed(x) < -16'sd2048) return 12'h800;
    return x[11:0];
  endfunction : sat

  task automatic wr(input logic [4:0] a, input apo_nib_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd

  task automatic wait_irq;
    int i;
    i = 0;
    while (audio_irq !== 1'b1 && i < WMAX * TD) begin
      @(posedge clk);
      i++;
    end
    if (audio_irq !== 1'b1) fail("no interrupt");
  endtask : wait_irq

  // Service routine: flag seen, then cleared
  task automatic isr;
    rd(`APO_OFF_STATUS);
    chk_reg(rv, 4'h4);
    wr(`APO_OFF_STATUS, 4'h0);
    repeat (3) @(posedge clk);
  endtask : isr

  task automatic put(input logic [11:0] x);
    wr(`APO_OFF_SMP_LO, x[3:0]);
    wr(`APO_OFF_SMP_MID, x[7:4]);
    wr(`APO_OFF_SMP_HI, x[11:8]);
  endtask : put

  // Window of whole delta-sigma periods holds the full duty in highs
  task automatic measure(input logic [11:0] x, input int r);
    logic [12:0] pos_e, mx;
    logic [11:0] duty;
    int n;
    mx = (13'h1 << (8 + 2 * r)) - 13'h1;
    duty = f ? x : x ^ 12'h800;
    n = ((x & ~(12'hFFF << (4 - 2 * r))) != 12'h000) ?
      (1 << (4 - 2 * r)) : 1;
    pos_e = 13'((duty * n) >> (4 - 2 * r));
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat ((mx + 1) * n * TD) @(posedge clk);
    #1;
    chk_cnt(pos_hi, pos_e * TD);
    chk_cnt(neg_hi, (mx * n - pos_e) * TD);
  endtask : measure

  task automatic start(input int r, input logic [11:0] x);
    wr(`APO_OFF_CTRL, 4'h0);
    repeat (2) @(posedge clk);
    #1;
    chk_pin(spk_pos | spk_neg, 1'b0);
    chk_pin(spk_oe, 1'b1);
    wr(`APO_OFF_RES, 4'(r));
    wr(`APO_OFF_FMT, {2'b00, f, 1'b0});
    wr(`APO_OFF_STATUS, 4'h0);
    put(x);
    wr(`APO_OFF_CTRL, 4'h3);
    wait_irq();
    isr();
    measure(x, r);
  endtask : start

  task automatic follow(input int r, input logic [11:0] x);
    wait_irq();
    isr();
    put(x);
    wait_irq();
    isr();
    measure(x, r);
  endtask : follow

  task automatic results;
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    #800_000;
    bad_count++;
    results();
  end

  initial begin
    void'($urandom(32'h775C));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(`APO_OFF_FMT);
    chk_reg(rv, 4'h0);
    rd(5'h05);
    chk_reg(rv, 4'h0);
    rd(`APO_OFF_SMP_LO);
    chk_reg(rv, 4'h0);
    wr(`APO_OFF_FMT, 4'h8);
    rd(`APO_OFF_FMT);
    chk_reg(rv & 4'hA, 4'h8);
    chk_pin(wake_enable, 1'b1);
    for (int i = 0; i < 12; i++) begin
      v = (i < 5) ? corners[i] : 16'($urandom);
      for (int k = 0; k < 4; k++) wr(`APO_OFF_SAT, v[4*k +: 4]);
      for (int k = 0; k < 3; k++) begin
        rd(`APO_OFF_SAT);
        chk_reg(rv, 4'(sat(v) >> (4 * k)));
      end
    end
    for (int r = 2; r >= 0; r--) begin
      f = (r == 1);
      m = 12'hFFF << (4 - 2 * r);
      start(r, 12'($urandom) & m);
      follow(r, f ? 12'h000 : 12'h800);
      follow(r, (f ? 12'hFFF : 12'h7FF) & m);
      for (int k = 0; k < 4 * (1 - r / 2) * (r == 0); k++) begin
        // Low bits left set so the delta-sigma carry is exercised
        follow(r, 12'($urandom) & 12'hBFF);
      end
    end
    wr(`APO_OFF_CTRL, 4'h1);
    repeat (300) begin
      @(posedge clk);
      #1;
      chk_pin(audio_irq, 1'b0);
    end
    rd(`APO_OFF_STATUS);
    chk_reg(rv, 4'h4);
    wr(`APO_OFF_CTRL, 4'h3);
    repeat (3) @(posedge clk);
    #1;
    chk_pin(audio_irq, 1'b1);
    @(posedge clk);
    halt_req <= 1'b1;
    @(posedge clk);
    halt_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk_pin(spk_oe, 1'b0);
    chk_pin(floated, 1'b1);
    rd(`APO_OFF_CTRL);
    chk_reg(rv & 4'h1, 4'h0);
    wr(`APO_OFF_CTRL, 4'h3);
    repeat (3) @(posedge clk);
    #1;
    chk_pin(spk_oe, 1'b1);
    rd(`APO_OFF_CTRL);
    chk_reg(rv & 4'h3, 4'h3);
    results();
  end
endmodule : apo_pwm_out_tb_top

// *** verification/apo_speaker_model.sv ***
// Loudspeaker model across the two speaker pins
`timescale 1ns/1ps
module apo_speaker_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pos,
  input wire logic neg,
  input wire logic oe,
  input wire logic clr,
  output logic [12:0] pos_hi,
  output logic [12:0] neg_hi,
  output logic floated
);
  // ------------------------------------------------------------
  // Drive counters
  // ------------------------------------------------------------
  // Pins count only while driven; floating pins move no cone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_hi <= 13'h0000;
      neg_hi <= 13'h0000;
    end else if (clr) begin
      pos_hi <= 13'h0000;
      neg_hi <= 13'h0000;
    end else begin
      pos_hi <= pos_hi + 13'(oe & pos);
      neg_hi <= neg_hi + 13'(oe & neg);
    end
  end
  assign floated = !oe;
endmodule : apo_speaker_model
